/* File: verilog/three_wire_serial_eeprom_core.sv */
// What this block does
// - Organization select high gives 16-bit words
// - Serial input sampled on rising clock edges
// - Output floats except read data or status
// - Status low while busy, high when ready
// - Start bit: chip select and input high
// - Nothing happens before a start bit
// - Execute only after all bits arrived
// - Two-bit opcode, extended by top address
// - Ignore link after last bit until start, or until deselect after enable/disable
// - Programming disabled until enable command
// - Reads work regardless of write enable
// - Read gives zero then word, MSB first
// - Read bits change on rising clock
// - Continued clocking streams following words
// - Erase sets word to ones at A0
// - Write programs data, starts at D0
// - Status shown until next start bit or deselect
// - Chip select low: standby, cycle completes
// - Erase-all sets whole array to ones
// - Erase-all and write-all ignore low address
// - Write-all erases then fills, needs enable
// - Self-timed, erase-all 15, write-all 30 ms
// - Single word cycle about 3 ms
// - Chip select low resets command logic
// - Program enable pin low blocks programming
`include "serial_eeprom_cfg.svh"
`default_nettype none

module three_wire_serial_eeprom_core #(
    parameter logic [23:0] WORD_CYCLES = 24'(`WORD_CYCLES),
    parameter logic [23:0] ERASE_ALL_CYCLES = 24'(`ERASE_ALL_CYCLES),
    parameter logic [23:0] WRITE_ALL_CYCLES = 24'(`WRITE_ALL_CYCLES),
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Serial link from the host
    input wire logic i_cs,
    input wire logic i_sclk,
    input wire logic i_serial_in,
    // Serial output, tri-state as value plus enable
    output logic o_serial_out,
    output logic o_serial_out_en,
    // Straps
    input wire logic i_organization_select,
    input wire logic i_program_enable_pin,
    // Status
    output logic o_busy,
    output logic o_write_enabled
);

    // ==========================================================
    // Reset release and state
    logic rst_n_meta;
    logic rst_n_sync;
    serial_eeprom_pkg::core_state_type cur;
    serial_eeprom_pkg::core_state_type next_cur;
    logic [7:0] mem [0:2047];

    // Release is synchronised so all flops leave reset on one edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_n_meta <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_n_meta <= 1'b1;
            rst_n_sync <= rst_n_meta;
        end
    end

    // ==========================================================
    // Read path prefetch FIFO
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [15:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [15:0] fifo_out_data;

    word_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) prefetch (
        .i_clk(i_clk),
        .i_rst_n(rst_n_sync),
        .i_flush(cur.flush),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data)
    );

    // ==========================================================
    // Derived link terms
    logic rise;
    logic x16;
    logic prog_ok;
    logic busy;
    logic [4:0] addr_end;
    logic [4:0] data_end;
    logic [26:0] nsr;
    logic [4:0] k;
    logic [1:0] op_in;
    logic [1:0] sub_in;
    logic [10:0] addr_in;
    logic [15:0] data_in;
    logic [15:0] aligned;
    logic [7:0] wbyte;

    assign rise = cur.ck2 && !cur.ck_prev;
    assign x16 = cur.org2;
    assign prog_ok = cur.wen && cur.pe2;
    assign busy = cur.prog != serial_eeprom_pkg::prog_idle;
    assign addr_end = x16 ? 5'(`OPCODE_BITS + `X16_ADDR_BITS) : 5'(`OPCODE_BITS + `X8_ADDR_BITS);
    assign data_end = x16 ? 5'(`OPCODE_BITS + `X16_ADDR_BITS + `X16_DATA_BITS)
                          : 5'(`OPCODE_BITS + `X8_ADDR_BITS + `X8_DATA_BITS);
    assign nsr = {cur.sr[25:0], cur.di2};
    assign k = cur.bitcnt + 5'h01;

    // Field extraction for the frame as it stands after this bit
    always_comb begin
        if (x16) begin
            op_in = nsr[11:10];
            sub_in = nsr[9:8];
            addr_in = {1'b0, nsr[9:0]};
        end else begin
            op_in = nsr[12:11];
            sub_in = nsr[10:9];
            addr_in = nsr[10:0];
        end
        data_in = x16 ? nsr[15:0] : {8'h00, nsr[7:0]};
    end

    // Word fetch: x16 pairs two bytes, high byte at the odd address
    assign fifo_in_data = x16 ? {mem[{cur.fetch_ptr[9:0], 1'b1}], mem[{cur.fetch_ptr[9:0], 1'b0}]}
                              : {8'h00, mem[cur.fetch_ptr]};
    assign fifo_in_valid = (cur.state == serial_eeprom_pkg::st_read) && !cur.flush;
    assign fifo_out_ready = (cur.state == serial_eeprom_pkg::st_read) && rise && (cur.out_cnt == 5'h00);
    assign aligned = x16 ? fifo_out_data : {fifo_out_data[7:0], 8'h00};

    // Byte written by the engine this cycle
    always_comb begin
        if (cur.erase_first) begin
            wbyte = 8'hff;
        end else if (cur.prog_x16 && cur.wa[0]) begin
            wbyte = cur.wval[15:8];
        end else begin
            wbyte = cur.wval[7:0];
        end
    end

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_cur = cur;
        next_cur.flush = 1'b0;
        // Pins enter through two flops each
        next_cur.cs1 = i_cs;
        next_cur.cs2 = cur.cs1;
        next_cur.ck1 = i_sclk;
        next_cur.ck2 = cur.ck1;
        next_cur.ck_prev = cur.ck2;
        next_cur.di1 = i_serial_in;
        next_cur.di2 = cur.di1;
        next_cur.org1 = i_organization_select;
        next_cur.org2 = cur.org1;
        next_cur.pe1 = i_program_enable_pin;
        next_cur.pe2 = cur.pe1;

        // Self-timed engine runs with no link clock at all
        if (busy && cur.timer != 24'h000000) begin
            next_cur.timer = cur.timer - 24'h000001;
        end
        unique case (cur.prog)
            serial_eeprom_pkg::prog_idle: begin
            end
            serial_eeprom_pkg::prog_walk: begin
                if (cur.wa == cur.wend) begin
                    if (cur.erase_first && cur.wval != `ERASED_WORD) begin
                        next_cur.erase_first = 1'b0;
                        next_cur.wa = 11'h000;
                    end else begin
                        next_cur.prog = serial_eeprom_pkg::prog_wait;
                    end
                end else begin
                    next_cur.wa = cur.wa + 11'h001;
                end
            end
            serial_eeprom_pkg::prog_wait: begin
                if (cur.timer == 24'h000000) begin
                    next_cur.prog = serial_eeprom_pkg::prog_idle;
                end
            end
        endcase

        // Prefetch pointer wraps within the selected organization
        if (fifo_in_valid && fifo_in_ready) begin
            next_cur.fetch_ptr = x16 ? {1'b0, cur.fetch_ptr[9:0] + 10'h001} : cur.fetch_ptr + 11'h001;
        end

        if (!cur.cs2) begin
            // Deselected: standby, command logic held, cycle continues
            next_cur.state = serial_eeprom_pkg::st_idle;
            next_cur.sdo_en = 1'b0;
            next_cur.sdo = 1'b0;
            next_cur.bitcnt = 5'h00;
            next_cur.flush = 1'b1;
        end else begin
            unique case (cur.state)
                serial_eeprom_pkg::st_idle, serial_eeprom_pkg::st_status: begin
                    // A start bit is honoured only when the engine is free
                    if (rise && cur.di2 && !busy) begin
                        next_cur.state = serial_eeprom_pkg::st_shift;
                        next_cur.bitcnt = 5'h00;
                        next_cur.sr = '0;
                        next_cur.sdo_en = 1'b0;
                    end
                end
                serial_eeprom_pkg::st_shift: begin
                    if (rise) begin
                        next_cur.sr = nsr;
                        next_cur.bitcnt = k;
                        if (k == addr_end) begin
                            next_cur.op = op_in;
                            next_cur.sub = sub_in;
                            next_cur.addr = addr_in;
                            unique case (op_in)
                                `OP_READ: begin
                                    // Dummy zero goes out on the last address edge
                                    next_cur.state = serial_eeprom_pkg::st_read;
                                    next_cur.sdo = 1'b0;
                                    next_cur.sdo_en = 1'b1;
                                    next_cur.out_cnt = 5'h00;
                                    next_cur.fetch_ptr = addr_in;
                                    next_cur.flush = 1'b1;
                                end
                                `OP_ERASE: begin
                                    next_cur.state = serial_eeprom_pkg::st_status;
                                    if (prog_ok) begin
                                        // Word erase starts on the A0 edge
                                        next_cur.prog = serial_eeprom_pkg::prog_walk;
                                        next_cur.timer = WORD_CYCLES - 24'h000001;
                                        next_cur.wa = x16 ? {addr_in[9:0], 1'b0} : addr_in;
                                        next_cur.wend = x16 ? {addr_in[9:0], 1'b1} : addr_in;
                                        next_cur.wval = `ERASED_WORD;
                                        next_cur.erase_first = 1'b0;
                                        next_cur.prog_x16 = x16;
                                    end
                                end
                                `OP_WRITE: begin
                                end
                                `OP_EXT: begin
                                    unique case (sub_in)
                                        `EXT_WRITE_ENABLE: begin
                                            next_cur.wen = 1'b1;
                                            next_cur.state = serial_eeprom_pkg::st_done;
                                        end
                                        `EXT_WRITE_DISABLE: begin
                                            next_cur.wen = 1'b0;
                                            next_cur.state = serial_eeprom_pkg::st_done;
                                        end
                                        `EXT_ERASE_ALL: begin
                                            next_cur.state = serial_eeprom_pkg::st_status;
                                            if (prog_ok) begin
                                                // Low address bits play no part
                                                next_cur.prog = serial_eeprom_pkg::prog_walk;
                                                next_cur.timer = ERASE_ALL_CYCLES - 24'h000001;
                                                next_cur.wa = 11'h000;
                                                next_cur.wend = 11'h7ff;
                                                next_cur.wval = `ERASED_WORD;
                                                next_cur.erase_first = 1'b0;
                                                next_cur.prog_x16 = x16;
                                            end
                                        end
                                        `EXT_WRITE_ALL: begin
                                        end
                                    endcase
                                end
                            endcase
                        end else if (k == data_end) begin
                            // Data complete: programming starts on the D0 edge
                            next_cur.state = serial_eeprom_pkg::st_status;
                            if (prog_ok) begin
                                next_cur.prog = serial_eeprom_pkg::prog_walk;
                                next_cur.wval = data_in;
                                next_cur.prog_x16 = x16;
                                if (cur.op == `OP_WRITE) begin
                                    next_cur.timer = WORD_CYCLES - 24'h000001;
                                    next_cur.wa = x16 ? {cur.addr[9:0], 1'b0} : cur.addr;
                                    next_cur.wend = x16 ? {cur.addr[9:0], 1'b1} : cur.addr;
                                    next_cur.erase_first = 1'b0;
                                end else begin
                                    // Whole array: erase pass first, then fill pass
                                    next_cur.timer = WRITE_ALL_CYCLES - 24'h000001;
                                    next_cur.wa = 11'h000;
                                    next_cur.wend = 11'h7ff;
                                    next_cur.erase_first = 1'b1;
                                end
                            end
                        end
                    end
                end
                serial_eeprom_pkg::st_read: begin
                    if (rise) begin
                        if (cur.out_cnt == 5'h00) begin
                            // Next word from the prefetch; pointer already ahead
                            next_cur.sdo = aligned[15];
                            next_cur.out_word = {aligned[14:0], 1'b0};
                            next_cur.out_cnt = x16 ? 5'(`X16_DATA_BITS - 1) : 5'(`X8_DATA_BITS - 1);
                        end else begin
                            next_cur.sdo = cur.out_word[15];
                            next_cur.out_word = {cur.out_word[14:0], 1'b0};
                            next_cur.out_cnt = cur.out_cnt - 5'h01;
                        end
                    end
                end
                serial_eeprom_pkg::st_done: begin
                    // Frame complete: link is don't-care until deselect
                    next_cur.sdo_en = 1'b0;
                end
            endcase
        end

        // Polled status: low while the engine runs, high once free
        if (cur.cs2 && next_cur.state == serial_eeprom_pkg::st_status) begin
            next_cur.sdo_en = 1'b1;
            next_cur.sdo = next_cur.prog == serial_eeprom_pkg::prog_idle;
        end
        // Busy registered here so the output pin comes from a flop
        next_cur.prog_busy = next_cur.prog != serial_eeprom_pkg::prog_idle;
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // Array has no reset: contents are nonvolatile in intent
    always_ff @(posedge i_clk) begin
        if (cur.prog == serial_eeprom_pkg::prog_walk) begin
            mem[cur.wa] <= wbyte;
        end
    end

    // ==========================================================
    // Outputs straight from flops
    assign o_serial_out = cur.sdo;
    assign o_serial_out_en = cur.sdo_en;
    assign o_busy = cur.prog_busy;
    assign o_write_enabled = cur.wen;

endmodule

`default_nettype wire

/* File: verilog/serial_eeprom_cfg.svh */
`ifndef SERIAL_EEPROM_CFG_SVH
`define SERIAL_EEPROM_CFG_SVH

// ==========================================================
// Clock and self-timed cycle lengths
`define CLK_MHZ 100
`define T_WORD_US 3000
`define T_ERASE_ALL_US 15000
`define T_WRITE_ALL_US 30000
`define WORD_CYCLES (`T_WORD_US * `CLK_MHZ)
`define ERASE_ALL_CYCLES (`T_ERASE_ALL_US * `CLK_MHZ)
`define WRITE_ALL_CYCLES (`T_WRITE_ALL_US * `CLK_MHZ)

// ==========================================================
// Opcodes and the sub-codes carried by the top address bits
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define OP_ERASE 2'h3
`define OP_EXT 2'h0
`define EXT_WRITE_ENABLE 2'h3
`define EXT_ERASE_ALL 2'h2
`define EXT_WRITE_ALL 2'h1
`define EXT_WRITE_DISABLE 2'h0

// ==========================================================
// Frame lengths after the start bit, and fill values
`define OPCODE_BITS 2
`define X16_ADDR_BITS 10
`define X8_ADDR_BITS 11
`define X16_DATA_BITS 16
`define X8_DATA_BITS 8
`define ERASED_WORD 16'hffff

`endif

/* File: verilog/serial_eeprom_pkg.sv */
`default_nettype none

package serial_eeprom_pkg;

    // ==========================================================
    // Command sequencer and programming engine states
    typedef enum logic [2:0] {
        st_idle,
        st_shift,
        st_read,
        st_status,
        st_done
    } link_state_type;

    typedef enum logic [1:0] {
        prog_idle,
        prog_walk,
        prog_wait
    } prog_state_type;

    // ==========================================================
    // Complete register state of the core
    typedef struct packed {
        logic prog_busy;
        logic cs1;
        logic cs2;
        logic ck1;
        logic ck2;
        logic ck_prev;
        logic di1;
        logic di2;
        logic org1;
        logic org2;
        logic pe1;
        logic pe2;
        link_state_type state;
        logic [26:0] sr;
        logic [4:0] bitcnt;
        logic [1:0] op;
        logic [1:0] sub;
        logic [10:0] addr;
        logic wen;
        logic sdo;
        logic sdo_en;
        logic [15:0] out_word;
        logic [4:0] out_cnt;
        logic [10:0] fetch_ptr;
        logic flush;
        prog_state_type prog;
        logic [23:0] timer;
        logic [10:0] wa;
        logic [10:0] wend;
        logic [15:0] wval;
        logic erase_first;
        logic prog_x16;
    } core_state_type;

endpackage

`default_nettype wire

/* File: verilog/word_fifo.sv */
`default_nettype none

module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_flush,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } fifo_state_type;

    fifo_state_type cur;
    fifo_state_type next_cur;
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic push;
    logic pop;

    // ==========================================================
    // Honest flags from the occupancy count, both gated off during a flush
    assign o_in_ready = (cur.count != (AW+1)'(DEPTH)) && !i_flush;
    assign o_out_valid = (cur.count != '0) && !i_flush;
    assign o_out_data = store[cur.rd];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Pointer update; a flush drops everything held
    always_comb begin
        next_cur = cur;
        if (i_flush) begin
            next_cur = '0;
        end else begin
            if (push) begin
                next_cur.wr = cur.wr + 1'b1;
            end
            if (pop) begin
                next_cur.rd = cur.rd + 1'b1;
            end
            next_cur.count = cur.count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // Storage carries no reset, only valid entries are ever read
    always_ff @(posedge i_clk) begin
        if (push) begin
            store[cur.wr] <= i_in_data;
        end
    end

endmodule

`default_nettype wire

/* File: verification/eeprom_host.sv */
`default_nettype none
module eeprom_host (
    // Clock for edge alignment
    input wire logic i_clk,
    // Link to the device
    output logic o_cs,
    output logic o_sclk,
    output logic o_di,
    // Returned data line
    input wire logic i_do
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Idle link: the serial clock stands low outside frames
    initial begin
        o_cs = 1'b0;
        o_sclk = 1'b0;
        o_di = 1'b0;
    end
    // Shift n bits MSB first, sampling the line before each rise
    task automatic send(input logic [31:0] v, input int n, output logic [31:0] r);
        @(posedge i_clk) #1 r = '0;
        o_cs = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            o_di = v[i];
            #40 r = {r[30:0], i_do};
            o_sclk = 1'b1;
            #40 o_sclk = 1'b0;
        end
    endtask
    // Deselect long enough to clear the command logic
    task automatic drop();
        @(posedge i_clk) #1 o_cs = 1'b0;
        #400;
    endtask
endmodule
`default_nettype wire

/* File: verification/eeprom_core_monitor.sv */
`default_nettype none
module eeprom_core_monitor (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Link and straps
    input wire logic i_cs,
    input wire logic i_program_enable_pin,
    input wire logic o_serial_out,
    input wire logic o_serial_out_en,
    input wire logic o_busy,
    input wire logic o_write_enabled
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ==========================================
    // Steps of a deselect and of a self-timed cycle start
    sequence s_deselect;
        !i_cs [*6];
    endsequence
    sequence s_cycle_start;
        !o_busy ##1 o_busy;
    endsequence
    a_float_deselected: assert property (s_deselect |-> !o_serial_out_en)
        else $error("output driven while deselected");
    a_busy_drives_low: assert property (o_busy && o_serial_out_en |-> !o_serial_out)
        else $error("status not low while busy");
    a_ready_goes_high: assert property ($fell(o_busy) && i_cs && o_serial_out_en |-> ##[0:2] o_serial_out)
        else $error("status not high once ready");
    a_pin_blocks_prog: assert property (!i_program_enable_pin [*8] |-> !$rose(o_busy))
        else $error("programming started with pin low");
    a_cycle_needs_wen: assert property (s_cycle_start |-> o_write_enabled)
        else $error("programming started while disabled");
    a_cycle_min_len: assert property (s_cycle_start |=> o_busy [*8])
        else $error("self-timed cycle too short");
    a_wen_busy_stable: assert property (o_busy && $past(o_busy) |-> $stable(o_write_enabled))
        else $error("command taken during cycle");
    a_status_holds: assert property (o_busy && o_serial_out_en && i_cs |=> o_serial_out_en)
        else $error("status dropped while selected");
endmodule
bind three_wire_serial_eeprom_core eeprom_core_monitor u_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_cs(i_cs), .i_program_enable_pin(i_program_enable_pin), .o_serial_out(o_serial_out),
    .o_serial_out_en(o_serial_out_en), .o_busy(o_busy), .o_write_enabled(o_write_enabled));
`default_nettype wire

/* File: verification/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, cs, sclk, di, organization_select, pe, dout, dout_en, busy, wen, do_line;
    logic [31:0] r;
    logic last_do = 1'b0;
    int error_cnt = 0;
    int n_checks = 0;
    // Released line shows the inverse of the last driven value
    always @(dout_en or dout) begin
        if (dout_en) begin
            last_do = dout;
        end
    end
    assign do_line = dout_en ? dout : ~last_do;
    three_wire_serial_eeprom_core #(.WORD_CYCLES(24'h00012c), .ERASE_ALL_CYCLES(24'h001388),
        .WRITE_ALL_CYCLES(24'h001388)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_cs(cs), .i_sclk(sclk),
        .i_serial_in(di), .o_serial_out(dout), .o_serial_out_en(dout_en), .i_organization_select(organization_select),
        .i_program_enable_pin(pe), .o_busy(busy), .o_write_enabled(wen));
    eeprom_host host (.i_clk(clk), .o_cs(cs), .o_sclk(sclk), .o_di(di), .i_do(do_line));
    // ==========================================
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Bounded wait for the self-timed cycle to end
    task automatic idle(input int limit);
        for (int k = 0; k < limit && busy !== 1'b0; k++) @(posedge clk) #1;
    endtask
    // Ready must show on the line while still selected
    task automatic settle(input int limit);
        idle(limit);
        repeat (3) @(posedge clk);
        #1 chk("ready", do_line, 1);
        host.drop();
    endtask
    task automatic rd(input logic [31:0] v, input int n, input logic [16:0] exp);
        host.send(v, n, r);
        chk("read", r[16:0], exp);
        host.drop();
    endtask
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        host.send({1'b1, 2'h1, a, d}, 22, r);
        settle(1000);
    endtask
    // Watchdog: the run needs about 160 us, this allows 40000 cycles
    initial begin
        #400000;
        error_cnt++;
        conclude();
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        organization_select = 1'b0;
        pe = 1'b1;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 chk("wen_reset", wen, 0);
        host.send(32'h0, 9, r);
        chk("no_start", {busy, dout_en}, 0);
        host.drop();
        wr(11'h010, 8'h3c);
        host.send({1'b1, 2'h0, 2'h3, 9'h1ff}, 14, r);
        chk("wen_set", {wen, dout_en}, 2'b10);
        host.drop();
        host.send({1'b1, 2'h0, 2'h1, 9'h155, 8'h5a}, 22, r);
        chk("busy_low", do_line, 0);
        settle(6000);
        rd({1'b1, 2'h2, 11'h7ff, 17'h0}, 31, {1'b0, 8'h5a, 8'h5a});
        host.send({1'b1, 2'h0, 2'h2, 9'h0ab}, 14, r);
        host.drop();
        chk("standby", {busy, dout_en}, 2'b10);
        idle(6000);
        chk("done", busy, 0);
        rd({1'b1, 2'h2, 11'h123, 17'h0}, 31, {1'b0, 8'hff, 8'hff});
        wr(11'h010, 8'h3c);
        wr(11'h011, 8'hc3);
        rd({1'b1, 2'h2, 11'h010, 17'h0}, 31, {1'b0, 8'h3c, 8'hc3});
        host.send({1'b1, 2'h3, 11'h011}, 14, r);
        wr(11'h011, 8'h00);
        rd({1'b1, 2'h2, 11'h010, 17'h0}, 31, {1'b0, 8'h3c, 8'hff});
        pe = 1'b0;
        host.send({1'b1, 2'h1, 11'h010, 8'h00}, 22, r);
        chk("pin_block", busy, 0);
        settle(10);
        pe = 1'b1;
        organization_select = 1'b1;
        rd({1'b1, 2'h2, 10'h008, 17'h0}, 30, {1'b0, 16'hff3c});
        host.send({1'b1, 2'h1, 10'h009, 16'ha55a}, 29, r);
        settle(1000);
        rd({1'b1, 2'h2, 10'h009, 17'h0}, 30, {1'b0, 16'ha55a});
        host.send({1'b1, 2'h0, 2'h0, 8'h00}, 13, r);
        chk("wen_clear", wen, 0);
        host.drop();
        rd({1'b1, 2'h2, 10'h008, 17'h0}, 30, {1'b0, 16'hff3c});
        conclude();
    end
endmodule
`default_nettype wire
